/* File: rtl/override_pkg.sv */
package override_pkg;

  // Clock and fixed link timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int FIXED_BAUD      = 300;
  localparam int BIT_CYCLES_300  = CLK_HZ / FIXED_BAUD;
  localparam int DEBOUNCE_US     = 10_000;
  localparam int DEBOUNCE_CYCLES = CLK_HZ / 1_000_000 * DEBOUNCE_US;
  localparam int CNT_W           = 17;
  localparam int DB_W            = 18;

  // Register offsets
  localparam logic [3:0] SETUP_OFS  = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] RXDATA_OFS = 4'h8;
  localparam logic [3:0] TXDATA_OFS = 4'hc;

  // Bit positions in status, receive and transmit words
  localparam int ST_OVR_BIT   = 0;
  localparam int ST_RXV_BIT   = 1;
  localparam int ST_TXB_BIT   = 2;
  localparam int ST_ERR_BIT   = 3;
  localparam int ST_BAUD_LSB  = 4;
  localparam int ST_PAR_LSB   = 7;
  localparam int RX_FIRST_BIT = 8;
  localparam int RX_HASH_BIT  = 9;
  localparam int TX_ERR_BIT   = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Command characters
  localparam logic [7:0] CH_NUL    = 8'h00;
  localparam logic [7:0] CH_CR     = 8'h0d;
  localparam logic [7:0] CH_HASH   = 8'h23;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_QMARK  = 8'h3f;
  localparam logic [7:0] CH_LBRACE = 8'h7b;
  localparam logic [7:0] CH_RBRACE = 8'h7d;

  typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_t;

  // Stored setup word, lowest field in the low bits
  typedef struct packed {
    logic [1:0] delay;
    logic       alarm;
    logic       echo;
    logic       lf;
    parity_t    par;
    logic [2:0] baud;
    logic [7:0] addr;
  } setup_t;

  localparam int SETUP_W = 18;
  localparam logic [2:0] BAUD_300 = 3'h0;

  localparam setup_t FACTORY_SETUP = '{
    delay : 2'h2,
    alarm : 1'b0,
    echo  : 1'b0,
    lf    : 1'b0,
    par   : PAR_NONE,
    baud  : BAUD_300,
    addr  : 8'h31
  };

endpackage

/* File: rtl/override_if.sv */
`timescale 1ns/1ps
interface override_if;
  logic active;
  logic released;
  modport src (output active, output released);
  modport dst (input active, input released);
endinterface

/* File: rtl/override_debounce.sv */
`timescale 1ns/1ps
module override_debounce #(
  parameter int DEBOUNCE_CYCLES = override_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic aclk,      // System clock
  input  wire logic aresetn,   // Synchronous reset, low
  input  wire logic default_n, // Override pin, low forces default
  override_if.src   ovr        // Debounced level and release pulse
);

  typedef struct packed {
    logic                            s1;
    logic                            s2;
    logic                            active;
    logic                            released;
    logic [override_pkg::DB_W-1:0]   cnt;
  } db_t;

  db_t r_reg;
  db_t r_next;

  // Synchronise, then accept a change only after it stays put
  always_comb begin
    r_next          = r_reg;
    r_next.released = 1'b0;
    r_next.s1       = ~default_n;
    r_next.s2       = r_reg.s1;
    if (r_reg.s2 == r_reg.active) begin
      r_next.cnt = '0;
    end else if (r_reg.cnt ==
                 override_pkg::DB_W'(DEBOUNCE_CYCLES - 1)) begin
      r_next.cnt      = '0;
      r_next.active   = r_reg.s2;
      r_next.released = r_reg.active;
    end else begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end
    if (!aresetn) begin
      r_next = '0;
    end
  end

  always_ff @(posedge aclk) begin
    r_reg <= r_next;
  end

  assign ovr.active   = r_reg.active;
  assign ovr.released = r_reg.released;

endmodule

/* File: rtl/serial_default_mode_override.sv */
// Behaviour
// - Override pin low forces 300 baud, 8 data bits, 1 stop, no parity.
// - In override, any address except NUL, CR, $, #, { and } is accepted.
// - Entering override never alters the stored setup.
// - No command is blocked by override; accepted frames pass on whole.
// - Stored setup, address included, stays readable during override.
// - Error reply is a question mark then the stored address character.
// - Setup writes in override change only the store, not the live link.
// - Pin release does a program reset and loads the stored link format.
// - Setup lives in a store that only power-on reset restores.
// - Setup may be written at any time.
// - Factory setup is address 1, 300 baud, no parity, delay two.
`timescale 1ns/1ps
module serial_default_mode_override #(
  parameter int BIT_CYCLES_300  = override_pkg::BIT_CYCLES_300,
  parameter int DEBOUNCE_CYCLES = override_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic        aclk,            // System clock
  input  wire logic        aresetn,         // Synchronous reset, low
  input  wire logic        default_n,       // Override pin, low active
  input  wire logic        rxd,             // Serial receive line
  output logic             txd,             // Serial transmit line
  output logic             prog_reset,      // Program reset pulse
  output logic             override_active, // Override mode in force
  input  wire logic [3:0]  awaddr,          // Write address
  input  wire logic [2:0]  awprot,          // Write protection, unused
  input  wire logic        awvalid,         // Write address valid
  output logic             awready,         // Write address ready
  input  wire logic [31:0] wdata,           // Write data
  input  wire logic [3:0]  wstrb,           // Write byte enables
  input  wire logic        wvalid,          // Write data valid
  output logic             wready,          // Write data ready
  output logic [1:0]       bresp,           // Write response
  output logic             bvalid,          // Write response valid
  input  wire logic        bready,          // Write response ready
  input  wire logic [3:0]  araddr,          // Read address
  input  wire logic [2:0]  arprot,          // Read protection, unused
  input  wire logic        arvalid,         // Read address valid
  output logic             arready,         // Read address ready
  output logic [31:0]      rdata,           // Read data
  output logic [1:0]       rresp,           // Read response
  output logic             rvalid,          // Read data valid
  input  wire logic        rready           // Read data ready
);

  localparam int CW = override_pkg::CNT_W;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } rx_state_t;
  typedef enum logic [1:0] {FR_IDLE, FR_ADDR, FR_BODY} frame_state_t;

  typedef struct packed {
    override_pkg::setup_t setup;
    override_pkg::setup_t live;
    logic                 awready;
    logic                 wready;
    logic                 aw_got;
    logic                 w_got;
    logic [3:0]           aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic                 rx_s1;
    logic                 rx_s2;
    rx_state_t            rx_st;
    logic [CW-1:0]        rx_cnt;
    logic [3:0]           rx_bit;
    logic [7:0]           rx_shift;
    logic                 rx_perr;
    frame_state_t         fr_st;
    logic                 fr_hash;
    logic                 fr_first;
    logic [7:0]           rx_char;
    logic                 rx_first;
    logic                 rx_hash;
    logic                 rx_valid;
    logic                 rx_err;
    logic                 tx_busy;
    logic [CW-1:0]        tx_cnt;
    logic [3:0]           tx_left;
    logic [10:0]          tx_shift;
    logic                 tx_addr_pend;
    logic                 txd;
    logic                 prog_reset;
    logic                 ovr;
  } state_t;

  state_t r_reg;
  state_t r_next;

  override_if ovr_bus ();

  // Pin filter
  override_debounce #(
    .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
  ) u_debounce (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .default_n (default_n),
    .ovr       (ovr_bus.src)
  );

  // Link format in force: fixed while overridden, else latched copy
  logic [2:0]            eff_baud;
  override_pkg::parity_t eff_par;
  logic [CW-1:0]         bit_len;
  logic [CW-1:0]         half_len;

  assign eff_baud = ovr_bus.active ? override_pkg::BAUD_300
                                   : r_reg.live.baud;
  assign eff_par  = ovr_bus.active ? override_pkg::PAR_NONE
                                   : r_reg.live.par;
  assign bit_len  = CW'(BIT_CYCLES_300 >> eff_baud) - 1'b1;
  assign half_len = bit_len >> 1;

  // Address check for a frame
  function automatic logic addr_ok(input logic [7:0] c, input logic ov,
                                   input logic [7:0] own);
    logic illegal;
    illegal = (c == override_pkg::CH_NUL) || (c == override_pkg::CH_CR) ||
              (c == override_pkg::CH_DOLLAR) ||
              (c == override_pkg::CH_HASH) ||
              (c == override_pkg::CH_LBRACE) ||
              (c == override_pkg::CH_RBRACE);
    return ov ? !illegal : (c == own);
  endfunction

  // Parity bit of a character under the given format
  function automatic logic par_bit(input logic [7:0] c,
                                   input override_pkg::parity_t p);
    return (p == override_pkg::PAR_ODD) ? ~^c : ^c;
  endfunction

  localparam state_t RESET_STATE = '{
    setup    : override_pkg::FACTORY_SETUP,
    live     : override_pkg::FACTORY_SETUP,
    rx_s1    : 1'b1,
    rx_s2    : 1'b1,
    txd      : 1'b1,
    rx_st    : RX_IDLE,
    fr_st    : FR_IDLE,
    default  : '0
  };

  // Next state of the whole block
  always_comb begin
    logic [31:0] wv;
    logic        got;
    logic [7:0]  ch;
    logic        use_par;
    wv      = '0;
    got     = 1'b0;
    ch      = '0;
    use_par = (eff_par == override_pkg::PAR_EVEN) ||
              (eff_par == override_pkg::PAR_ODD);
    r_next            = r_reg;
    r_next.prog_reset = ovr_bus.released;
    r_next.ovr        = ovr_bus.active;

    // Write address and data, taken in either order
    if (awvalid && r_reg.awready) begin
      r_next.aw_got  = 1'b1;
      r_next.aw_addr = awaddr;
      r_next.awready = 1'b0;
    end
    if (wvalid && r_reg.wready) begin
      r_next.w_got  = 1'b1;
      r_next.w_data = wdata;
      r_next.w_strb = wstrb;
      r_next.wready = 1'b0;
    end
    if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
      r_next.aw_got = 1'b0;
      r_next.w_got  = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp  = override_pkg::RESP_OKAY;
      if ({r_reg.aw_addr[3:2], 2'b00} == override_pkg::SETUP_OFS) begin
        wv = 32'(r_reg.setup);
        for (int i = 0; i < 4; i++) begin
          if (r_reg.w_strb[i]) begin
            wv[8*i +: 8] = r_reg.w_data[8*i +: 8];
          end
        end
        r_next.setup =
          override_pkg::setup_t'(wv[override_pkg::SETUP_W-1:0]);
      end else if ({r_reg.aw_addr[3:2], 2'b00} ==
                   override_pkg::TXDATA_OFS) begin
        if (r_reg.w_strb[0] && !r_reg.tx_busy) begin
          ch = r_reg.w_data[override_pkg::TX_ERR_BIT]
               ? override_pkg::CH_QMARK : r_reg.w_data[7:0];
          r_next.tx_addr_pend =
            r_reg.w_data[override_pkg::TX_ERR_BIT];
          r_next.tx_busy  = 1'b1;
          r_next.tx_cnt   = bit_len;
          r_next.tx_shift = {1'b1, use_par ? par_bit(ch, eff_par) : 1'b1,
                             ch, 1'b0};
          r_next.tx_left  = use_par ? 4'd11 : 4'd10;
          r_next.txd      = 1'b0;
        end
      end else if ({r_reg.aw_addr[3:2], 2'b00} !=
                   override_pkg::STATUS_OFS &&
                   {r_reg.aw_addr[3:2], 2'b00} !=
                   override_pkg::RXDATA_OFS) begin
        r_next.bresp = override_pkg::RESP_SLVERR;
      end
    end
    if (r_reg.bvalid && bready) begin
      r_next.bvalid  = 1'b0;
      r_next.awready = 1'b1;
      r_next.wready  = 1'b1;
    end

    // Read channel; reading the receive word clears its flag
    if (arvalid && r_reg.arready) begin
      r_next.arready = 1'b0;
      r_next.rvalid  = 1'b1;
      r_next.rresp   = override_pkg::RESP_OKAY;
      r_next.rdata   = '0;
      if ({araddr[3:2], 2'b00} == override_pkg::SETUP_OFS) begin
        r_next.rdata = 32'(r_reg.setup);
      end else if ({araddr[3:2], 2'b00} == override_pkg::STATUS_OFS) begin
        r_next.rdata[override_pkg::ST_OVR_BIT] = ovr_bus.active;
        r_next.rdata[override_pkg::ST_RXV_BIT] = r_reg.rx_valid;
        r_next.rdata[override_pkg::ST_TXB_BIT] = r_reg.tx_busy;
        r_next.rdata[override_pkg::ST_ERR_BIT] = r_reg.rx_err;
        r_next.rdata[override_pkg::ST_BAUD_LSB +: 3] = eff_baud;
        r_next.rdata[override_pkg::ST_PAR_LSB +: 2]  = eff_par;
      end else if ({araddr[3:2], 2'b00} == override_pkg::RXDATA_OFS) begin
        r_next.rdata[7:0] = r_reg.rx_char;
        r_next.rdata[override_pkg::RX_FIRST_BIT] = r_reg.rx_first;
        r_next.rdata[override_pkg::RX_HASH_BIT]  = r_reg.rx_hash;
        r_next.rx_valid = 1'b0;
        r_next.rx_err   = 1'b0;
      end else if ({araddr[3:2], 2'b00} != override_pkg::TXDATA_OFS) begin
        r_next.rresp = override_pkg::RESP_SLVERR;
      end
    end
    if (r_reg.rvalid && rready) begin
      r_next.rvalid  = 1'b0;
      r_next.arready = 1'b1;
    end

    // Receiver, sampling at mid bit
    r_next.rx_s1 = rxd;
    r_next.rx_s2 = r_reg.rx_s1;
    if (r_reg.rx_st != RX_IDLE) begin
      r_next.rx_cnt = r_reg.rx_cnt - 1'b1;
    end
    case (r_reg.rx_st)
      RX_IDLE: begin
        if (!r_reg.rx_s2) begin
          r_next.rx_st  = RX_START;
          r_next.rx_cnt = half_len;
        end
      end
      RX_START: begin
        if (r_reg.rx_cnt == '0) begin
          r_next.rx_cnt  = bit_len;
          r_next.rx_bit  = '0;
          r_next.rx_perr = 1'b0;
          r_next.rx_st   = r_reg.rx_s2 ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (r_reg.rx_cnt == '0) begin
          r_next.rx_cnt   = bit_len;
          r_next.rx_shift = {r_reg.rx_s2, r_reg.rx_shift[7:1]};
          r_next.rx_bit   = r_reg.rx_bit + 1'b1;
          if (r_reg.rx_bit == 4'd7) begin
            r_next.rx_st = use_par ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (r_reg.rx_cnt == '0) begin
          r_next.rx_cnt  = bit_len;
          r_next.rx_perr = r_reg.rx_s2 != par_bit(r_reg.rx_shift, eff_par);
          r_next.rx_st   = RX_STOP;
        end
      end
      RX_STOP: begin
        if (r_reg.rx_cnt == '0) begin
          r_next.rx_st = RX_IDLE;
          if (r_reg.rx_s2 && !r_reg.rx_perr) begin
            got = 1'b1;
          end else begin
            r_next.rx_err = 1'b1;
          end
        end
      end
      default: r_next.rx_st = RX_IDLE;
    endcase

    // Frame filter: pass every body character of an addressed frame
    if (got) begin
      if (r_reg.rx_shift == override_pkg::CH_DOLLAR ||
          r_reg.rx_shift == override_pkg::CH_HASH) begin
        r_next.fr_st   = FR_ADDR;
        r_next.fr_hash = r_reg.rx_shift == override_pkg::CH_HASH;
      end else begin
        case (r_reg.fr_st)
          FR_ADDR: begin
            r_next.fr_first = 1'b1;
            r_next.fr_st = addr_ok(r_reg.rx_shift, ovr_bus.active,
                                   r_reg.setup.addr) ? FR_BODY : FR_IDLE;
          end
          FR_BODY: begin
            r_next.rx_char  = r_reg.rx_shift;
            r_next.rx_first = r_reg.fr_first;
            r_next.rx_hash  = r_reg.fr_hash;
            r_next.rx_valid = 1'b1;
            r_next.fr_first = 1'b0;
            if (r_reg.rx_shift == override_pkg::CH_CR) begin
              r_next.fr_st = FR_IDLE;
            end
          end
          default: r_next.fr_st = FR_IDLE;
        endcase
      end
    end

    // Transmitter, low bit first
    if (r_reg.tx_busy) begin
      r_next.tx_cnt = r_reg.tx_cnt - 1'b1;
      if (r_reg.tx_cnt == '0) begin
        r_next.tx_cnt   = bit_len;
        r_next.tx_shift = r_reg.tx_shift >> 1;
        r_next.tx_left  = r_reg.tx_left - 1'b1;
        r_next.txd      = r_reg.tx_shift[1];
        if (r_reg.tx_left == 4'd1 && r_reg.tx_addr_pend) begin
          ch = r_reg.setup.addr;
          r_next.tx_addr_pend = 1'b0;
          r_next.tx_shift = {1'b1, use_par ? par_bit(ch, eff_par) : 1'b1,
                             ch, 1'b0};
          r_next.tx_left  = use_par ? 4'd11 : 4'd10;
          r_next.txd      = 1'b0;
        end else if (r_reg.tx_left == 4'd1) begin
          r_next.tx_busy = 1'b0;
          r_next.txd     = 1'b1;
        end
      end
    end

    // Program reset on release: link restarts, store kept
    if (ovr_bus.released) begin
      r_next.live     = r_reg.setup;
      r_next.rx_st    = RX_IDLE;
      r_next.fr_st    = FR_IDLE;
      r_next.rx_valid = 1'b0;
      r_next.rx_err   = 1'b0;
      r_next.tx_busy  = 1'b0;
      r_next.tx_addr_pend = 1'b0;
      r_next.txd      = 1'b1;
    end

    // Power-on reset restores the factory store
    if (!aresetn) begin
      r_next = RESET_STATE;
    end else if (r_reg.awready == 1'b0 && r_reg.wready == 1'b0 &&
                 r_reg.arready == 1'b0 && !r_reg.aw_got &&
                 !r_reg.w_got && !r_reg.bvalid && !r_reg.rvalid) begin
      r_next.awready = 1'b1;
      r_next.wready  = 1'b1;
      r_next.arready = 1'b1;
    end
  end

  // Single state register; override never writes the store
  always_ff @(posedge aclk) begin
    r_reg <= r_next;
  end

  assign txd             = r_reg.txd;
  assign prog_reset      = r_reg.prog_reset;
  assign override_active = r_reg.ovr;
  assign awready         = r_reg.awready;
  assign wready          = r_reg.wready;
  assign bresp           = r_reg.bresp;
  assign bvalid          = r_reg.bvalid;
  assign arready         = r_reg.arready;
  assign rdata           = r_reg.rdata;
  assign rresp           = r_reg.rresp;
  assign rvalid          = r_reg.rvalid;

endmodule

/* File: bench/override_assertions.sv */
`timescale 1ns/1ps
module override_assertions #(
  parameter int BIT_CYCLES_300  = 16,
  parameter int DEBOUNCE_CYCLES = 4
) (
  input wire logic       aclk,            // Clock
  input wire logic       aresetn,         // Reset, low
  input wire logic       default_n,       // Override pin
  input wire logic       txd,             // Serial out
  input wire logic       prog_reset,      // Program reset
  input wire logic       override_active, // Override state
  input wire logic       awvalid,         // AW valid
  input wire logic       awready,         // AW ready
  input wire logic       wvalid,          // W valid
  input wire logic       wready,          // W ready
  input wire logic [1:0] bresp,           // B response
  input wire logic       bvalid,          // B valid
  input wire logic       bready,          // B ready
  input wire logic       arvalid,         // AR valid
  input wire logic       arready,         // AR ready
  input wire logic [1:0] rresp,           // R response
  input wire logic       rvalid,          // R valid
  input wire logic       rready           // R ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Override follows a settled pin only
  property p_ovr_rise;
    $rose(override_active) |-> !$past(default_n, 3);
  endproperty
  a_ovr_rise: assert property (p_ovr_rise)
    else $error("override entered with pin high");
  property p_ovr_fall;
    $fell(override_active) |-> $past(default_n, 3);
  endproperty
  a_ovr_fall: assert property (p_ovr_fall)
    else $error("override left with pin low");

  // Program reset only on release, one cycle
  property p_rel_pin;
    prog_reset |-> default_n && $past(default_n, 2);
  endproperty
  a_rel_pin: assert property (p_rel_pin)
    else $error("program reset without pin release");
  property p_rel_pulse;
    prog_reset |=> !prog_reset;
  endproperty
  a_rel_pulse: assert property (p_rel_pulse)
    else $error("program reset longer than one cycle");

  // Fixed slow bit time while overridden
  property p_tx_low;
    $fell(txd) && override_active |-> !txd [*8] ##1 !txd [*8];
  endproperty
  a_tx_low: assert property (p_tx_low)
    else $error("low bit too short in override");
  property p_tx_high;
    $rose(txd) && override_active |-> txd [*8] ##1 txd [*8];
  endproperty
  a_tx_high: assert property (p_tx_high)
    else $error("high bit too short in override");

  // Register bus answers
  property p_wr_resp;
    awvalid && awready && wvalid && wready
      |-> ##2 bvalid && bresp == override_pkg::RESP_OKAY;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response late or not okay");
  property p_b_once;
    bvalid && bready |=> !bvalid;
  endproperty
  a_b_once: assert property (p_b_once)
    else $error("write response repeated");
  property p_rd_resp;
    arvalid && arready |=> rvalid && rresp == override_pkg::RESP_OKAY;
  endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("read response late or not okay");
  property p_r_once;
    rvalid && rready |=> !rvalid;
  endproperty
  a_r_once: assert property (p_r_once)
    else $error("read response repeated");

  // Main scenarios reached
  c_enter: cover property ($rose(override_active));
  c_release: cover property (prog_reset);
  c_write: cover property (bvalid && bready);
endmodule

bind serial_default_mode_override override_assertions #(
  .BIT_CYCLES_300(BIT_CYCLES_300), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) override_assertions_inst (.aclk, .aresetn, .default_n, .txd,
  .prog_reset, .override_active, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .arvalid, .arready, .rresp, .rvalid, .rready);

/* File: bench/host_model.sv */
`timescale 1ns/1ps
module host_model #(
  parameter int BIT = 16
) (
  input  wire logic aclk, // Clock
  input  wire logic txd,  // Device transmit
  output logic      rxd   // Device receive
);
  logic [7:0] got [$];

  // Idle line high
  initial rxd = 1'b1;

  // One character, start, 8 data LSB first, stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge aclk);
    end
  endtask

  // Frame mark, address, one body character
  task automatic send_cmd(input logic [7:0] a, input logic [7:0] c);
    send(override_pkg::CH_DOLLAR);
    send(a);
    send(c);
  endtask

  // Receive at mid-bit, fixed slow rate
  always begin
    logic [7:0] b;
    @(negedge txd);
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge aclk);
      b[i] = txd;
    end
    repeat (BIT) @(posedge aclk);
    got.push_back(b);
  end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
  localparam int BIT = 16;
  localparam logic [7:0] BAD [6] = '{override_pkg::CH_NUL,
    override_pkg::CH_CR, override_pkg::CH_LBRACE, override_pkg::CH_RBRACE,
    override_pkg::CH_DOLLAR, override_pkg::CH_HASH};
  logic        aclk, aresetn, default_n, rxd, txd;
  logic        prog_reset, override_active;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [2:0]  awprot, arprot;
  logic [1:0]  bresp, rresp;
  logic [31:0] wdata, rdata, rv;
  int          error_cnt, n_tests;
  override_pkg::setup_t cfg;

  // Device and serial host
  serial_default_mode_override #(.BIT_CYCLES_300(BIT),
    .DEBOUNCE_CYCLES(4)) serial_default_mode_override_inst (.aclk,
    .aresetn, .default_n, .rxd, .txd, .prog_reset, .override_active,
    .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  host_model #(.BIT(BIT)) host_model_inst (.aclk, .txd, .rxd);

  // 50 ns clock
  always #25 aclk = ~aclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Bus write, both channels offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    bready <= 1'b0;
    chk({29'h0, bvalid, bresp}, 32'h4);
  endtask

  // Bus read
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rready <= 1'b0;
    d = rvalid && rresp == override_pkg::RESP_OKAY ? rdata : 32'hdead_beef;
  endtask

  task automatic wait_rx(input int k);
    for (int n = 0; n < 1000 && host_model_inst.got.size() < k; n++)
      @(posedge aclk);
    repeat (BIT) @(posedge aclk);
  endtask

  // Factory setup after power-on
  task automatic t_reset();
    rd(override_pkg::SETUP_OFS, rv);
    chk(rv, 32'(override_pkg::FACTORY_SETUP));
    rd(override_pkg::STATUS_OFS, rv);
    chk(32'(rv[0]), 32'h0);
    $display("t_reset done");
  endtask

  // Pin grounded: fixed format, store kept
  task automatic t_enter();
    default_n <= 1'b0;
    for (int n = 0; n < 50 && override_active !== 1'b1; n++)
      @(posedge aclk);
    chk(32'(override_active), 32'h1);
    rd(override_pkg::SETUP_OFS, rv);
    chk(rv, 32'(override_pkg::FACTORY_SETUP));
    rd(override_pkg::STATUS_OFS, rv);
    chk(32'(rv[8:4]), 32'h0);
    $display("t_enter done");
  endtask

  // Setup write in override changes store only
  task automatic t_setup();
    cfg = override_pkg::FACTORY_SETUP;
    cfg.baud = 3'h2;
    cfg.par = override_pkg::PAR_EVEN;
    wr(override_pkg::SETUP_OFS, 32'(cfg));
    wr(override_pkg::STATUS_OFS, 32'hffff_ffff);
    rd(override_pkg::SETUP_OFS, rv);
    chk(rv, 32'(cfg));
    rd(override_pkg::STATUS_OFS, rv);
    chk(32'(rv[8:4]), 32'h0);
    $display("t_setup done");
  endtask

  // A legal address accepted, illegal ones dropped
  task automatic t_rx();
    host_model_inst.send_cmd(8'h5a, 8'h52);
    rd(override_pkg::RXDATA_OFS, rv);
    chk(32'(rv[9:0]), 32'h152);
    for (int i = 0; i < 6; i++) begin
      host_model_inst.send_cmd(BAD[i], 8'h52);
      rd(override_pkg::STATUS_OFS, rv);
      chk(32'(rv[3:1]), 32'h0);
    end
    $display("t_rx done");
  endtask

  // Plain character, then error reply with own address
  task automatic t_tx();
    wr(override_pkg::TXDATA_OFS, 32'h41);
    wait_rx(1);
    chk(32'(host_model_inst.got[0]), 32'h41);
    wr(override_pkg::TXDATA_OFS, 32'h100);
    wait_rx(3);
    chk(32'(host_model_inst.got[1]), 32'h3f);
    chk(32'(host_model_inst.got[2]), 32'h31);
    $display("t_tx done");
  endtask

  // Release: program reset, stored format goes live
  task automatic t_release();
    default_n <= 1'b1;
    for (int n = 0; n < 50 && prog_reset !== 1'b1; n++)
      @(posedge aclk);
    chk(32'(prog_reset), 32'h1);
    repeat (3) @(posedge aclk);
    rd(override_pkg::STATUS_OFS, rv);
    chk({23'h0, rv[8:4], 3'h0, rv[0]}, 32'h0a0);
    rd(override_pkg::SETUP_OFS, rv);
    chk(rv, 32'(cfg));
    $display("t_release done");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Reset, scenarios, verdict
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    default_n = 1'b1;
    wstrb = 4'hf;
    {awaddr, araddr, awprot, arprot, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_enter();
    t_setup();
    t_rx();
    t_tx();
    t_release();
    stop_test();
  end

  // Watchdog far beyond the expected run
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    stop_test();
  end
endmodule
